// ==== mcsr_regs.sv ====
// special register bank: timer, code pointer, stack, status, bank select, interrupt flags
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// - timer counts instruction cycles or pin edges
// - timer write alone clears timer-owned prescaler
// - pointer and stack entries are ten bits
// - reset forces pointer to zero
// - branch loads low ten pointer bits
// - call loads target, pushes next address
// - all returns reload pointer from stack
// - add/move accumulator to pointer, clear bits
// - pointer writes clear bits eight and nine
// - pointer-changing instructions take extra cycle
// - page bits load into upper address bits
// - returns keep page bits unchanged
// - time-out bit: set sleep/clear, cleared timeout
// - power bit: set clear-instr, cleared sleep
// - bank select holds bank and indirect address
// - external falling edge sets sticky flag
// - timer overflow sets sticky flag
// - software clears flags, never sets them
// - flag read returns flags AND mask
// - control bits choose timer source and edge
// - prescaler owner and ratio selection
// - global enable cleared/set by instructions
// - mask bits enable each interrupt source
`timescale 1ns/1ps
`include "mcsr_map.svh"
module mcsr_regs #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              cycleSlow,
    input  mcsr_pkg::mcsr_op_t     opCode,
    input  wire logic [9:0]        opTarget,
    input  wire logic [7:0]        accum,
    input  wire logic              regWrEn,
    input  wire logic              regWrIo,
    input  wire logic [5:0]        regWrAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regRdEn,
    input  wire logic              regRdIo,
    input  wire logic [5:0]        regRdAddr,
    input  wire logic              timerPin,
    input  wire logic              extIrqPin_n,
    input  wire logic              wdtSrcTick,
    input  wire logic              wdtTimeout,
    output logic                   cycleTick,
    output logic                   branchStall,
    output logic [11:0]            codeAddr,
    output logic [7:0]             regRdData,
    output logic [7:0]             bankSelect,
    output logic                   irqRequest,
    output logic                   wdtDivTick,
    output logic                   wdtDivClear
);
    if (STACK_DEPTH < 2 || STACK_DEPTH > 16) begin : g_chk
        $error("stack depth out of range");
    end

    //------------------------------------------------------------------
    // reset release
    //------------------------------------------------------------------
    logic rstMeta_ff;
    logic rstSync_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    //------------------------------------------------------------------
    // decode
    //------------------------------------------------------------------
    mcsr_pkg::mcsr_state_t s_ff;
    mcsr_pkg::mcsr_state_t nxt_s;
    mcsr_stack_if #(.WIDTH(10)) stkIf ();

    logic       act;
    logic       wrGo;
    logic       pclWr;
    logic       timerWr;
    logic       flagsWr;
    logic       jmpGo;
    logic       callGo;
    logic       retGo;
    logic       irqGo;
    logic       addGo;
    logic       branch;
    logic       pinEdge;
    logic       extFall;
    logic       timerOwn;
    logic       srcTick;
    logic [7:0] rateMask;
    logic [7:0] wdtMask;
    logic       timerInc;
    logic [1:0] psBits;
    logic [9:0] pcInc;

    assign act      = s_ff.cycleTick & ~s_ff.stall;
    assign wrGo     = act & regWrEn;
    assign pclWr    = wrGo & ~regWrIo & (regWrAddr == `MCSR_ADDR_PCL);
    assign timerWr  = wrGo & ~regWrIo & (regWrAddr == `MCSR_ADDR_TIMER);
    assign flagsWr  = wrGo & ~regWrIo & (regWrAddr == `MCSR_ADDR_FLAGS);
    assign jmpGo    = act & (opCode == mcsr_pkg::OP_JMP);
    assign callGo   = act & (opCode == mcsr_pkg::OP_CALL);
    assign retGo    = act & (opCode == mcsr_pkg::OP_RET || opCode == mcsr_pkg::OP_LITERAL_LOAD_EXIT_INSTR
                             || opCode == mcsr_pkg::OP_INTERRUPT_EXIT_INSTR);
    assign irqGo    = act & (opCode == mcsr_pkg::OP_IRQ);
    assign addGo    = act & (opCode == mcsr_pkg::OP_ADDPC);
    assign branch   = jmpGo | callGo | retGo | irqGo | addGo | pclWr;
    assign psBits   = s_ff.status[`MCSR_STAT_PS_HI:`MCSR_STAT_PS_LO];
    assign pcInc    = s_ff.pc + 10'h001;
    // only synchronised copies feed the edge detectors
    assign pinEdge  = s_ff.ctrl[`MCSR_CTRL_TE] ? (s_ff.tccPrev & ~s_ff.tccSync)
                                                : (~s_ff.tccPrev & s_ff.tccSync);
    assign extFall  = s_ff.intPrev & ~s_ff.intSync;
    assign timerOwn = ~s_ff.ctrl[`MCSR_CTRL_PAB];
    assign srcTick  = s_ff.ctrl[`MCSR_CTRL_TS] ? pinEdge : s_ff.cycleTick;
    // timer rates 1:2..1:256, watchdog rates 1:1..1:128
    assign rateMask = 8'hff >> (3'h7 - s_ff.ctrl[2:0]);
    assign wdtMask  = rateMask >> 1;
    assign timerInc = srcTick & (~timerOwn | ((s_ff.prescale & rateMask) == rateMask));

    assign stkIf.push     = callGo | irqGo;
    assign stkIf.pop      = retGo;
    assign stkIf.pushData = irqGo ? s_ff.pc : pcInc;

    mcsr_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (10)
    ) u_stack (
        .clock       (clock),
        .resetSync_n (rstSync_ff),
        .stk         (stkIf.store)
    );

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.tccMeta = timerPin;
        nxt_s.tccSync = s_ff.tccMeta;
        nxt_s.tccPrev = s_ff.tccSync;
        nxt_s.intMeta = extIrqPin_n;
        nxt_s.intSync = s_ff.intMeta;
        nxt_s.intPrev = s_ff.intSync;

        // instruction cycle is two or four clocks
        nxt_s.cycleTick = 1'b0;
        if (s_ff.divCnt == (cycleSlow ? `MCSR_DIV_SLOW : `MCSR_DIV_FAST)) begin
            nxt_s.divCnt    = 2'h0;
            nxt_s.cycleTick = 1'b1;
        end else begin
            nxt_s.divCnt = s_ff.divCnt + 2'h1;
        end

        // dummy cycle after a pointer change, no other work done in it
        if (s_ff.cycleTick && s_ff.stall) begin
            nxt_s.stall = 1'b0;
        end
        if (branch) begin
            nxt_s.stall = 1'b1;
        end

        // code pointer
        if (act) begin
            nxt_s.pc = pcInc;
        end
        if (jmpGo || callGo) begin
            nxt_s.pc   = opTarget;
            nxt_s.page = psBits;
        end
        if (retGo) begin
            nxt_s.pc = stkIf.topData;
        end
        if (irqGo) begin
            nxt_s.pc = `MCSR_IRQ_VECTOR;
        end
        if (addGo) begin
            nxt_s.pc   = {2'h0, s_ff.pc[7:0] + accum};
            nxt_s.page = psBits;
        end
        if (pclWr) begin
            nxt_s.pc   = {2'h0, regWrData};
            nxt_s.page = psBits;
        end

        // prescaler and timer
        nxt_s.wdtTick  = 1'b0;
        nxt_s.wdtClear = 1'b0;
        if (timerOwn) begin
            if (srcTick) begin
                nxt_s.prescale = s_ff.prescale + 8'h01;
            end
            nxt_s.wdtTick = wdtSrcTick;
        end else if (wdtSrcTick) begin
            nxt_s.prescale = s_ff.prescale + 8'h01;
            nxt_s.wdtTick  = (s_ff.prescale & wdtMask) == wdtMask;
        end
        if (timerInc) begin
            nxt_s.timer = s_ff.timer + 8'h01;
        end
        if (timerWr) begin
            nxt_s.timer = regWrData;
            if (timerOwn) begin
                nxt_s.prescale = 8'h00;
            end
        end
        if (act && (opCode == mcsr_pkg::OP_SLEEP || opCode == mcsr_pkg::OP_WATCHDOG_CLEAR_INSTR)) begin
            nxt_s.wdtClear = 1'b1;
            if (!timerOwn) begin
                nxt_s.prescale = 8'h00;
            end
        end

        // control, bank, mask
        if (wrGo && regWrIo && regWrAddr == `MCSR_IO_CTRL) begin
            nxt_s.ctrl = regWrData;
        end
        if (wrGo && regWrIo && regWrAddr == `MCSR_IO_MASK) begin
            nxt_s.mask = regWrData & `MCSR_FLAG_IMPL;
        end
        if (wrGo && !regWrIo && regWrAddr == `MCSR_ADDR_BANK) begin
            nxt_s.bank = regWrData;
        end
        if (act && (opCode == mcsr_pkg::OP_IRQ_DISABLE_INSTR || opCode == mcsr_pkg::OP_IRQ)) begin
            nxt_s.ctrl[`MCSR_CTRL_GIE] = 1'b0;
        end
        if (act && (opCode == mcsr_pkg::OP_ENI || opCode == mcsr_pkg::OP_INTERRUPT_EXIT_INSTR)) begin
            nxt_s.ctrl[`MCSR_CTRL_GIE] = 1'b1;
        end

        // status: time-out and power bits are not software writable
        if (wrGo && !regWrIo && regWrAddr == `MCSR_ADDR_STATUS) begin
            nxt_s.status = (regWrData & `MCSR_STAT_WRMASK) | (s_ff.status & ~`MCSR_STAT_WRMASK);
        end
        if (act && opCode == mcsr_pkg::OP_SLEEP) begin
            nxt_s.status[`MCSR_STAT_T] = 1'b1;
            nxt_s.status[`MCSR_STAT_P] = 1'b0;
        end
        if (act && opCode == mcsr_pkg::OP_WATCHDOG_CLEAR_INSTR) begin
            nxt_s.status[`MCSR_STAT_T] = 1'b1;
            nxt_s.status[`MCSR_STAT_P] = 1'b1;
        end
        if (wdtTimeout) begin
            nxt_s.status[`MCSR_STAT_T] = 1'b0;
        end

        // flags: writes can only clear, hardware set wins the same cycle
        if (flagsWr) begin
            nxt_s.flags = s_ff.flags & regWrData & `MCSR_FLAG_IMPL;
        end
        if (extFall) begin
            nxt_s.flags[`MCSR_FLAG_EXT] = 1'b1;
        end
        if (timerInc && s_ff.timer == `MCSR_TIMER_MAX) begin
            nxt_s.flags[`MCSR_FLAG_OVF] = 1'b1;
        end
        nxt_s.irqReq = s_ff.ctrl[`MCSR_CTRL_GIE] & (|(s_ff.flags & s_ff.mask));

        // read port, one clock latency
        if (regRdEn) begin
            nxt_s.rdData = 8'h00;
            if (regRdIo) begin
                if (regRdAddr == `MCSR_IO_CTRL) begin
                    nxt_s.rdData = s_ff.ctrl;
                end else if (regRdAddr == `MCSR_IO_MASK) begin
                    nxt_s.rdData = s_ff.mask;
                end
            end else begin
                unique case (regRdAddr)
                    `MCSR_ADDR_TIMER:  nxt_s.rdData = s_ff.timer;
                    `MCSR_ADDR_PCL:    nxt_s.rdData = s_ff.pc[7:0];
                    `MCSR_ADDR_STATUS: nxt_s.rdData = s_ff.status;
                    `MCSR_ADDR_BANK:   nxt_s.rdData = s_ff.bank;
                    `MCSR_ADDR_FLAGS:  nxt_s.rdData = s_ff.flags & s_ff.mask & `MCSR_FLAG_IMPL;
                    default:           nxt_s.rdData = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            s_ff         <= '0;
            s_ff.tccMeta <= 1'b0;
            s_ff.intMeta <= 1'b1;
            s_ff.intSync <= 1'b1;
            s_ff.intPrev <= 1'b1;
            s_ff.ctrl    <= `MCSR_CTRL_RST;
            s_ff.status  <= `MCSR_STATUS_RST;
            s_ff.bank    <= `MCSR_BANK_RST;
            s_ff.mask    <= `MCSR_MASK_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign cycleTick   = s_ff.cycleTick;
    assign branchStall = s_ff.stall;
    assign codeAddr    = {s_ff.page, s_ff.pc};
    assign regRdData   = s_ff.rdData;
    assign bankSelect  = s_ff.bank;
    assign irqRequest  = s_ff.irqReq;
    assign wdtDivTick  = s_ff.wdtTick;
    assign wdtDivClear = s_ff.wdtClear;

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync_ff);

    chk_pc_reset_zero: assert property (disable iff (1'b0) !rstSync_ff |-> codeAddr == 12'h000)
        else $error("code pointer not zero in reset");
    chk_jmp_target: assert property (jmpGo && !pclWr |=> codeAddr == {$past(psBits), $past(opTarget)})
        else $error("branch target not loaded");
    chk_call_push: assert property (callGo |=> ##1 stkIf.topData == $past(pcInc, 2))
        else $error("call did not push next address");
    chk_ret_restore: assert property (retGo && !pclWr
        |=> s_ff.pc == $past(stkIf.topData) && $stable(s_ff.page))
        else $error("return did not restore pointer");
    chk_add_clears: assert property (addGo && !pclWr
        |=> codeAddr[9:8] == 2'h0 && s_ff.pc[7:0] == 8'($past(s_ff.pc[7:0] + accum)))
        else $error("pointer add wrong");
    chk_pcl_write: assert property (pclWr |=> codeAddr == {$past(psBits), 2'h0, $past(regWrData)})
        else $error("pointer write wrong");
    chk_branch_stall: assert property (branch |=> branchStall throughout (##[1:4] cycleTick))
        else $error("no extra cycle after branch");
    chk_flag_read: assert property (regRdEn && !regRdIo && regRdAddr == `MCSR_ADDR_FLAGS
                                    |=> regRdData == $past(s_ff.flags & s_ff.mask))
        else $error("flag read not masked");
    chk_ovf_wrap: assert property (timerInc && !timerWr && s_ff.timer == `MCSR_TIMER_MAX
                                   |=> s_ff.timer == 8'h00 && s_ff.flags[`MCSR_FLAG_OVF])
        else $error("overflow not flagged");
    chk_flag_no_set: assert property (flagsWr && !extFall && !timerInc
        |=> (s_ff.flags & ~$past(s_ff.flags)) == 8'h00)
        else $error("software set a flag");
    chk_ext_flag: assert property (extFall |=> s_ff.flags[`MCSR_FLAG_EXT])
        else $error("external edge lost");
    chk_sleep_bits: assert property (act && opCode == mcsr_pkg::OP_SLEEP && !wdtTimeout
                                     |=> s_ff.status[`MCSR_STAT_T] && !s_ff.status[`MCSR_STAT_P])
        else $error("sleep status bits wrong");
    chk_gie_off: assert property (act && opCode == mcsr_pkg::OP_IRQ_DISABLE_INSTR |=> !s_ff.ctrl[`MCSR_CTRL_GIE])
        else $error("interrupt disable ignored");
    chk_prescale_clr: assert property (timerWr && timerOwn |=> s_ff.prescale == 8'h00)
        else $error("prescaler not cleared on timer write");

    cov_call_ret: cover property (callGo ##[1:40] retGo);
    cov_overflow: cover property (timerInc && s_ff.timer == `MCSR_TIMER_MAX);
    cov_irq_req: cover property (extFall ##[1:8] irqRequest);
endmodule : mcsr_regs

// ==== mcsr_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef MCSR_MAP_SVH
`define MCSR_MAP_SVH
`define MCSR_ADDR_TIMER   6'h01
`define MCSR_ADDR_PCL     6'h02
`define MCSR_ADDR_STATUS  6'h03
`define MCSR_ADDR_BANK    6'h04
`define MCSR_ADDR_FLAGS   6'h3f
`define MCSR_IO_CTRL      6'h01
`define MCSR_IO_MASK      6'h0f
`define MCSR_CTRL_GIE     6
`define MCSR_CTRL_TS      5
`define MCSR_CTRL_TE      4
`define MCSR_CTRL_PAB     3
`define MCSR_STAT_T       4
`define MCSR_STAT_P       3
`define MCSR_STAT_PS_HI   6
`define MCSR_STAT_PS_LO   5
`define MCSR_STAT_WRMASK  8'he7
`define MCSR_FLAG_EXT     3
`define MCSR_FLAG_OVF     0
`define MCSR_FLAG_IMPL    8'h09
`define MCSR_STATUS_RST   8'h18
`define MCSR_CTRL_RST     8'h00
`define MCSR_BANK_RST     8'h00
`define MCSR_MASK_RST     8'h00
`define MCSR_TIMER_MAX    8'hff
`define MCSR_DIV_FAST     2'h1
`define MCSR_DIV_SLOW     2'h3
`define MCSR_IRQ_VECTOR   10'h008
`endif

// ==== mcsr_pkg.sv ====
// types shared by the special register bank
package mcsr_pkg;
    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_JMP   = 4'h1,
        OP_CALL  = 4'h2,
        OP_RET   = 4'h3,
        OP_LITERAL_LOAD_EXIT_INSTR  = 4'h4,
        OP_INTERRUPT_EXIT_INSTR  = 4'h5,
        OP_SLEEP = 4'h6,
        OP_WATCHDOG_CLEAR_INSTR  = 4'h7,
        OP_ENI   = 4'h8,
        OP_IRQ_DISABLE_INSTR  = 4'h9,
        OP_ADDPC = 4'ha,
        OP_IRQ   = 4'hb
    } mcsr_op_t;

    typedef struct packed {
        logic       tccMeta;
        logic       tccSync;
        logic       tccPrev;
        logic       intMeta;
        logic       intSync;
        logic       intPrev;
        logic [1:0] divCnt;
        logic       cycleTick;
        logic       stall;
        logic [9:0] pc;
        logic [1:0] page;
        logic [7:0] timer;
        logic [7:0] prescale;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] bank;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] rdData;
        logic       irqReq;
        logic       wdtTick;
        logic       wdtClear;
    } mcsr_state_t;
endpackage : mcsr_pkg

// ==== mcsr_stack_if.sv ====
// push/pop link between the register bank and its return stack
`timescale 1ns/1ps
interface mcsr_stack_if #(parameter int WIDTH = 10);
    logic             push;
    logic             pop;
    logic [WIDTH-1:0] pushData;
    logic [WIDTH-1:0] topData;
    modport owner (output push, output pop, output pushData, input topData);
    modport store (input push, input pop, input pushData, output topData);
endinterface : mcsr_stack_if

// ==== mcsr_stack.sv ====
// circular hardware return stack with registered top entry
`timescale 1ns/1ps
module mcsr_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 10
) (
    input wire logic clock,
    input wire logic resetSync_n,
    mcsr_stack_if.store stk
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("stack depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               ptr;
        logic [WIDTH-1:0]            top;
    } mcsr_stk_state_t;

    mcsr_stk_state_t s_ff;
    mcsr_stk_state_t nxt_s;

    // overflow wraps and overwrites the oldest entry, as a small core expects
    always_comb begin
        nxt_s = s_ff;
        if (stk.push) begin
            nxt_s.mem[s_ff.ptr] = stk.pushData;
            nxt_s.ptr           = s_ff.ptr + PW'(1);
            nxt_s.top           = stk.pushData;
        end else if (stk.pop) begin
            nxt_s.ptr = s_ff.ptr - PW'(1);
            nxt_s.top = s_ff.mem[s_ff.ptr - PW'(2)];
        end
    end

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign stk.topData = s_ff.top;
endmodule : mcsr_stack

// ==== mcsr_env_model.sv ====
// pin and watchdog environment model around the special register bank
`timescale 1ns/1ps
module mcsr_env_model (
    input  wire logic clock,
    output logic      timerPin,
    output logic      extIrqPin_n,
    output logic      wdtTimeout
);
    //------------------------------------------------------------------
    // idle levels
    //------------------------------------------------------------------
    initial begin
        timerPin    = 1'b0;
        extIrqPin_n = 1'b1;
        wdtTimeout  = 1'b0;
    end

    //------------------------------------------------------------------
    // pin and event drivers
    //------------------------------------------------------------------
    // long settle: the synchroniser plus edge detect needs 3 clocks
    task automatic set_timer_pin(input logic level);
        @(negedge clock);
        timerPin = level;
        repeat (6) @(negedge clock);
    endtask : set_timer_pin

    task automatic ext_fall();
        @(negedge clock);
        extIrqPin_n = 1'b0;
        repeat (6) @(negedge clock);
        extIrqPin_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask : ext_fall

    task automatic wdt_timeout();
        @(negedge clock);
        wdtTimeout = 1'b1;
        @(negedge clock);
        wdtTimeout = 1'b0;
    endtask : wdt_timeout
endmodule : mcsr_env_model

// ==== mcsr_regs_tb.sv ====
// self-checking testbench for the special register bank
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %0t mismatch got %h expected %h", $time, (got), (exp)); end end
module mcsr_regs_tb;
    logic               clock;
    logic               reset_n;
    mcsr_pkg::mcsr_op_t opCode;
    logic [9:0]         opTarget;
    logic [7:0]         accum;
    logic               regWrEn;
    logic               regWrIo;
    logic [5:0]         regWrAddr;
    logic [7:0]         regWrData;
    logic               regRdEn;
    logic               regRdIo;
    logic [5:0]         regRdAddr;
    logic               timerPin;
    logic               extIrqPin_n;
    logic               wdtTimeout;
    logic               cycleTick;
    logic               branchStall;
    logic [11:0]        codeAddr;
    logic [7:0]         regRdData;
    logic               irqRequest;
    logic               cycleSlow, wdtSrcTick, wdtDivTick, wdtDivClear;
    logic [7:0]         bankSelect;
    int                 n;
    logic [7:0]         d;
    int                 err_count;
    int                 comparisons;
    mcsr_pkg::mcsr_op_t rets [3];

    //------------------------------------------------------------------
    // design and environment
    //------------------------------------------------------------------
    mcsr_regs dut (.clock(clock), .reset_n(reset_n), .cycleSlow(cycleSlow), .opCode(opCode), .opTarget(opTarget),
        .accum(accum), .regWrEn(regWrEn), .regWrIo(regWrIo), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdIo(regRdIo), .regRdAddr(regRdAddr), .timerPin(timerPin),
        .extIrqPin_n(extIrqPin_n), .wdtSrcTick(wdtSrcTick), .wdtTimeout(wdtTimeout), .cycleTick(cycleTick),
        .branchStall(branchStall), .codeAddr(codeAddr), .regRdData(regRdData), .bankSelect(bankSelect),
        .irqRequest(irqRequest), .wdtDivTick(wdtDivTick), .wdtDivClear(wdtDivClear));
    mcsr_env_model env (.clock(clock), .timerPin(timerPin), .extIrqPin_n(extIrqPin_n), .wdtTimeout(wdtTimeout));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    //------------------------------------------------------------------
    // access tasks
    //------------------------------------------------------------------
    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // requests only land in an accepted cycle, so wait for one first
    task automatic issue(input mcsr_pkg::mcsr_op_t op, input logic [9:0] tgt, input logic [7:0] acc,
                         input logic we, input logic [5:0] addr, input logic [7:0] data, input logic io);
        int n;
        n = 0;
        @(negedge clock);
        while (!(cycleTick === 1'b1 && branchStall === 1'b0)) begin
            n++;
            if (n > 20) begin
                err_count++;
                $display("[ERR] %0t no accepted cycle", $time);
                stop_test();
            end
            @(negedge clock);
        end
        opCode    = op;
        opTarget  = tgt;
        accum     = acc;
        regWrEn   = we;
        regWrIo   = io;
        regWrAddr = addr;
        regWrData = data;
        @(negedge clock);
        opCode    = mcsr_pkg::OP_NONE;
        regWrEn   = 1'b0;
    endtask : issue

    task automatic op(input mcsr_pkg::mcsr_op_t o, input logic [9:0] tgt);
        issue(o, tgt, 8'h00, 1'b0, 6'h00, 8'h00, 1'b0);
    endtask : op

    task automatic wr(input logic io, input logic [5:0] addr, input logic [7:0] data);
        issue(mcsr_pkg::OP_NONE, 10'h000, 8'h00, 1'b1, addr, data, io);
    endtask : wr

    task automatic rd(input logic io, input logic [5:0] addr, output logic [7:0] data);
        @(negedge clock);
        regRdEn   = 1'b1;
        regRdIo   = io;
        regRdAddr = addr;
        @(negedge clock);
        data      = regRdData;
        regRdEn   = 1'b0;
    endtask : rd

    task automatic chk_rd(input logic io, input logic [5:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        rd(io, addr, v);
        `CHECK(v, exp)
    endtask : chk_rd

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        reset_n     = 1'b0;
        opCode      = mcsr_pkg::OP_NONE;
        opTarget    = 10'h000;
        accum       = 8'h00;
        regWrEn     = 1'b0;
        regWrIo     = 1'b0;
        regWrAddr   = 6'h00;
        regWrData   = 8'h00;
        regRdEn     = 1'b0;
        regRdIo     = 1'b0;
        regRdAddr   = 6'h00;
        cycleSlow   = 1'b0;
        wdtSrcTick  = 1'b0;
        err_count   = 0;
        comparisons = 0;
        rets        = '{mcsr_pkg::OP_RET, mcsr_pkg::OP_LITERAL_LOAD_EXIT_INSTR, mcsr_pkg::OP_INTERRUPT_EXIT_INSTR};
        repeat (5) @(negedge clock);
        `CHECK(codeAddr, 12'h000)
        reset_n = 1'b1;
        repeat (3) @(negedge clock);
        chk_rd(1'b0, 6'h03, 8'h18);
        chk_rd(1'b0, 6'h05, 8'h00);
        wr(1'b0, 6'h04, 8'ha5);
        chk_rd(1'b0, 6'h04, 8'ha5);
        `CHECK(bankSelect, 8'ha5)
        // pointer loads and page extension
        wr(1'b0, 6'h03, 8'h60);
        op(mcsr_pkg::OP_JMP, 10'h3ff);
        `CHECK(codeAddr, 12'hfff)
        `CHECK(branchStall, 1'b1)
        wr(1'b0, 6'h02, 8'h55);
        `CHECK(codeAddr, 12'hc55)
        issue(mcsr_pkg::OP_ADDPC, 10'h000, 8'hc0, 1'b0, 6'h00, 8'h00, 1'b0);
        `CHECK(codeAddr, 12'hc15)
        // every return kind, with the page bits moved under it
        foreach (rets[i]) begin
            wr(1'b0, 6'h03, 8'h20);
            op(mcsr_pkg::OP_JMP, 10'h100);
            op(mcsr_pkg::OP_CALL, 10'h2aa);
            `CHECK(codeAddr, 12'h6aa)
            issue(rets[i], 10'h000, 8'h00, 1'b1, 6'h03, 8'h40, 1'b0);
            `CHECK(codeAddr, 12'h501)
        end
        // timer on pin edges, prescaler with the watchdog
        wr(1'b1, 6'h01, 8'h28);
        wr(1'b0, 6'h01, 8'hfe);
        env.set_timer_pin(1'b1);
        chk_rd(1'b0, 6'h01, 8'hff);
        env.set_timer_pin(1'b0);
        env.set_timer_pin(1'b1);
        chk_rd(1'b0, 6'h01, 8'h00);
        chk_rd(1'b0, 6'h3f, 8'h00);
        wr(1'b1, 6'h0f, 8'hff);
        chk_rd(1'b0, 6'h3f, 8'h01);
        env.set_timer_pin(1'b0);
        wr(1'b1, 6'h01, 8'h38);
        env.set_timer_pin(1'b1);
        env.set_timer_pin(1'b0);
        chk_rd(1'b0, 6'h01, 8'h01);
        // timer-owned prescaler at 1:2, cleared by a timer write, then watchdog-owned prescaler at 1:2
        wr(1'b1, 6'h01, 8'h20);
        wr(1'b0, 6'h01, 8'h10);
        for (int k = 0; k < 3; k++) begin
            env.set_timer_pin(1'b1);
            env.set_timer_pin(1'b0);
        end
        chk_rd(1'b0, 6'h01, 8'h11);
        wr(1'b0, 6'h01, 8'h20);
        env.set_timer_pin(1'b1);
        chk_rd(1'b0, 6'h01, 8'h20);
        env.set_timer_pin(1'b0);
        env.set_timer_pin(1'b1);
        chk_rd(1'b0, 6'h01, 8'h21);
        wr(1'b1, 6'h01, 8'h29);
        wdtSrcTick = 1'b1;
        n = 0;
        repeat (4) begin
            @(negedge clock);
            n += wdtDivTick;
        end
        wdtSrcTick = 1'b0;
        `CHECK(n, 2)
        // external flag, global enable, software clear
        env.ext_fall();
        chk_rd(1'b0, 6'h3f, 8'h09);
        op(mcsr_pkg::OP_ENI, 10'h000);
        repeat (3) @(negedge clock);
        `CHECK(irqRequest, 1'b1)
        op(mcsr_pkg::OP_IRQ, 10'h000);
        @(negedge clock);
        `CHECK(irqRequest, 1'b0)
        op(mcsr_pkg::OP_INTERRUPT_EXIT_INSTR, 10'h000);
        @(negedge clock);
        `CHECK(irqRequest, 1'b1)
        op(mcsr_pkg::OP_IRQ_DISABLE_INSTR, 10'h000);
        repeat (3) @(negedge clock);
        `CHECK(irqRequest, 1'b0)
        wr(1'b0, 6'h3f, 8'h00);
        chk_rd(1'b0, 6'h3f, 8'h00);
        wr(1'b0, 6'h3f, 8'hff);
        chk_rd(1'b0, 6'h3f, 8'h00);
        // time-out and power bits
        cycleSlow = 1'b1;
        op(mcsr_pkg::OP_SLEEP, 10'h000);
        `CHECK(wdtDivClear, 1'b1)
        n = 0;
        repeat (8) begin
            @(negedge clock);
            n += cycleTick;
        end
        `CHECK(n, 2)
        rd(1'b0, 6'h03, d);
        `CHECK(d & 8'h18, 8'h10)
        env.wdt_timeout();
        rd(1'b0, 6'h03, d);
        `CHECK(d & 8'h18, 8'h00)
        op(mcsr_pkg::OP_WATCHDOG_CLEAR_INSTR, 10'h000);
        rd(1'b0, 6'h03, d);
        `CHECK(d & 8'h18, 8'h18)
        stop_test();
    end
endmodule : mcsr_regs_tb
